/* core/phy_addr_map.sv */
// APB register bank mapping UTOPIA output PHY addresses to links/groups.
//
// Contract
// - Eight link address registers each pair link N with link N+8.
// - Link pair bits 12:8 hold link N+8's address, bits 4:0 link N's.
// - Bits 15:13 and 7:5 of link and group pair registers read zero.
// - Four group address registers each pair group N with group N+4.
// - Group pair bits 12:8 hold group N+4's address, bits 4:0 group N's.
// - The link enable register has bit n enabling link n, links 0..15.
// - All address and enable registers reset to zero, so all disabled.
// - The group enable register has bit n enabling group n, bits 7:0.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module phy_addr_map (
  input  wire logic                      pclk,           // Clock, 100 MHz
  input  wire logic                      presetn,        // Async reset
  input  wire logic                      ce,             // Clock enable
  input  wire logic                      psel,           // APB select
  input  wire logic                      penable,        // APB enable
  input  wire logic                      pwrite,         // APB direction
  input  wire logic [11:0]               paddr,          // APB byte addr
  input  wire logic [31:0]               pwdata,         // APB write data
  input  wire logic [3:0]                pstrb,          // APB byte lanes
  output logic      [31:0]               prdata,         // APB read data
  output logic                           pready,         // APB ready
  output logic                           pslverr,        // APB error
  input  wire addr_map_pkg::phy_addr_t   utopia_addr_pin, // Polled address
  output addr_map_pkg::phy_match_s       phy_match       // Poll result
);

  // Stored configuration
  addr_map_pkg::phy_addr_t link_addr_r [16];
  addr_map_pkg::phy_addr_t group_addr_r [8];
  logic [15:0]             link_en_r;
  logic [7:0]              group_en_r;

  // Bus answer registers
  logic [31:0]             prdata_r;
  logic [31:0]             prdata_nxt;
  logic                    pready_r;
  logic                    pslverr_r;
  logic                    pslverr_nxt;

  // Poll path
  addr_map_pkg::phy_addr_t poll_addr;
  addr_map_pkg::phy_match_s match_comb;
  addr_map_pkg::phy_match_s phy_match_r;

  // Pack a pair of five-bit fields; unused bits come back as zero
  function automatic logic [31:0] pair_word(
    input addr_map_pkg::phy_addr_t hi,
    input addr_map_pkg::phy_addr_t lo
  );
    logic [31:0] w;
    w = '0;
    w[addr_map_pkg::HI_LSB +: addr_map_pkg::ADDR_W] = hi;
    w[addr_map_pkg::LO_LSB +: addr_map_pkg::ADDR_W] = lo;
    return w;
  endfunction : pair_word

  // Field extraction, used for both link and group writes
  function automatic addr_map_pkg::phy_addr_t field(
    input logic [31:0] w,
    input int unsigned lsb
  );
    return w[lsb +: addr_map_pkg::ADDR_W];
  endfunction : field

  // Address decode
  wire  [9:0] idx       = paddr[11:2];
  wire        is_link   = (idx <= addr_map_pkg::IDX_LINK_PAIR_7);
  wire        is_group  = (idx >= addr_map_pkg::IDX_GROUP_PAIR_0) &&
                          (idx <= addr_map_pkg::IDX_GROUP_PAIR_3);
  wire        is_len    = (idx == addr_map_pkg::IDX_LINK_EN);
  wire        is_gen    = (idx == addr_map_pkg::IDX_GROUP_EN);
  wire        mapped    = is_link | is_group | is_len | is_gen;
  wire  [2:0] link_pair = idx[2:0];
  wire  [1:0] grp_pair  = 2'(idx - addr_map_pkg::IDX_GROUP_PAIR_0);

  // Phases: wait one access cycle, then complete on the pready edge
  wire        access    = psel & penable;
  wire        answer    = access & ~pready_r;
  wire        complete  = access & pready_r;
  wire        wr_ok     = complete & pwrite & mapped;
  wire        wr_lo     = pstrb[0];
  wire        wr_hi     = pstrb[1];

  // Read data selection for the addressed register
  always_comb
  begin
    prdata_nxt = addr_map_pkg::RST_RDATA;
    if (is_link)
      prdata_nxt = pair_word(link_addr_r[link_pair + 4'd8],
                             link_addr_r[link_pair]);
    else if (is_group)
      prdata_nxt = pair_word(group_addr_r[grp_pair + 3'd4],
                             group_addr_r[grp_pair]);
    else if (is_len)
      prdata_nxt = {16'h0000, link_en_r};
    else if (is_gen)
      prdata_nxt = {24'h000000, group_en_r};
  end

  assign pslverr_nxt = ~mapped;

  // Bus handshake; ready stands one cycle, error and data alongside
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= addr_map_pkg::RST_RDATA;
    end
    else if (ce)
    begin
      pready_r  <= answer;
      pslverr_r <= answer & pslverr_nxt;
      if (answer && !pwrite)
        prdata_r <= prdata_nxt;
      else if (!answer)
        prdata_r <= addr_map_pkg::RST_RDATA;
    end
  end

  // Link address pairs; byte lanes 0 and 1 each write one five-bit field
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < addr_map_pkg::N_LINKS; i++)
        link_addr_r[i] <= addr_map_pkg::RST_ADDR;
    end
    else if (ce && wr_ok && is_link)
    begin
      if (wr_lo)
        link_addr_r[link_pair] <= field(pwdata, addr_map_pkg::LO_LSB);
      if (wr_hi)
        link_addr_r[link_pair + 4'd8] <=
          field(pwdata, addr_map_pkg::HI_LSB);
    end
  end

  // Group address pairs; group N sits low, group N+4 high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < addr_map_pkg::N_GROUPS; i++)
        group_addr_r[i] <= addr_map_pkg::RST_ADDR;
    end
    else if (ce && wr_ok && is_group)
    begin
      if (wr_lo)
        group_addr_r[grp_pair] <= field(pwdata, addr_map_pkg::LO_LSB);
      if (wr_hi)
        group_addr_r[grp_pair + 3'd4] <=
          field(pwdata, addr_map_pkg::HI_LSB);
    end
  end

  // Link enables, one bit per link over both byte lanes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      link_en_r <= addr_map_pkg::RST_LINK_EN;
    else if (ce && wr_ok && is_len)
    begin
      if (wr_lo)
        link_en_r[7:0] <= pwdata[7:0];
      if (wr_hi)
        link_en_r[15:8] <= pwdata[15:8];
    end
  end

  // Group enables; upper bits of this word are held at zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      group_en_r <= addr_map_pkg::RST_GROUP_EN;
    else if (ce && wr_ok && is_gen && wr_lo)
      group_en_r <= pwdata[7:0];
  end

  // Polled address arrives from the ATM layer, so it is synchronised
  pin_sync #(
    .WIDTH     (addr_map_pkg::ADDR_W)
  ) u_poll_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .pin_in    (utopia_addr_pin),
    .value_out (poll_addr)
  );

  // Match against configured and enabled entries only
  phy_addr_match u_match (
    .link_addr  (link_addr_r),
    .group_addr (group_addr_r),
    .link_en    (link_en_r),
    .group_en   (group_en_r),
    .poll_addr  (poll_addr),
    .match      (match_comb)
  );

  // Registered so the poll result leaves the block from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phy_match_r <= '0;
    else if (ce)
      phy_match_r <= match_comb;
  end

  // Outputs straight from flops
  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign phy_match = phy_match_r;

endmodule : phy_addr_map
`default_nettype wire

/* core/addr_map_pkg.sv */
// Constants and types shared by the output PHY address map block.
package addr_map_pkg;

  // Sizes of the map
  localparam int unsigned N_LINKS     = 16;
  localparam int unsigned N_GROUPS    = 8;
  localparam int unsigned LINK_PAIRS  = 8;
  localparam int unsigned GROUP_PAIRS = 4;
  localparam int unsigned ADDR_W      = 5;
  localparam int unsigned APB_AW      = 12;
  localparam int unsigned IDX_W       = 10;
  localparam int unsigned SYNC_STAGES = 3;

  // Register indices; the APB byte address is four times the index
  localparam logic [9:0] IDX_LINK_PAIR_0  = 10'h000;
  localparam logic [9:0] IDX_LINK_PAIR_7  = 10'h007;
  localparam logic [9:0] IDX_GROUP_PAIR_0 = 10'h008;
  localparam logic [9:0] IDX_GROUP_PAIR_3 = 10'h00b;
  localparam logic [9:0] IDX_LINK_EN      = 10'h010;
  localparam logic [9:0] IDX_GROUP_EN     = 10'h011;

  // Field positions inside a pair register
  localparam int unsigned LO_LSB = 0;
  localparam int unsigned HI_LSB = 8;

  // Values after reset
  localparam logic [4:0]  RST_ADDR     = 5'h00;
  localparam logic [15:0] RST_LINK_EN  = 16'h0000;
  localparam logic [7:0]  RST_GROUP_EN = 8'h00;
  localparam logic [31:0] RST_RDATA    = 32'h0000_0000;

  // Five-bit UTOPIA PHY address
  typedef logic [4:0] phy_addr_t;

  // Result of matching the polled address against the map
  typedef struct packed {
    logic       hit;       // Address is configured and enabled
    logic       is_group;  // Hit belongs to an IMA group
    logic [3:0] index;     // Link or group number
  } phy_match_s;

endpackage : addr_map_pkg

/* core/pin_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             pclk,     // Block clock
  input  wire logic             presetn,  // Async reset, active low
  input  wire logic             ce,       // Clock enable
  input  wire logic [WIDTH-1:0] pin_in,   // Asynchronous pin value
  output logic      [WIDTH-1:0] value_out // Filtered, settled value
);

  logic [WIDTH-1:0] ff1_r;
  logic [WIDTH-1:0] ff2_r;
  logic [WIDTH-1:0] ff3_r;
  logic [WIDTH-1:0] value_r;
  wire              agree = (ff2_r == ff3_r);

  // First stage feeds only the second; a change counts once 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ff1_r   <= '0;
      ff2_r   <= '0;
      ff3_r   <= '0;
      value_r <= '0;
    end
    else if (ce)
    begin
      ff1_r <= pin_in;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      if (agree)
        value_r <= ff3_r;
    end
  end

  assign value_out = value_r;

endmodule : pin_sync
`default_nettype wire

/* core/phy_addr_match.sv */
// Combinational match of a polled PHY address against the address map.
`timescale 1ns/100ps
`default_nettype none
module phy_addr_match (
  input  wire addr_map_pkg::phy_addr_t link_addr [16], // Link addresses
  input  wire addr_map_pkg::phy_addr_t group_addr [8], // Group addresses
  input  wire logic [15:0]             link_en,        // Link enables
  input  wire logic [7:0]              group_en,       // Group enables
  input  wire addr_map_pkg::phy_addr_t poll_addr,      // Address polled
  output addr_map_pkg::phy_match_s     match           // Match result
);

  // Scan downwards so the lowest index wins; links take priority over
  // groups, since a duplicate address is a software fault either way.
  always_comb
  begin
    match = '0;
    for (int g = addr_map_pkg::N_GROUPS - 1; g >= 0; g--)
    begin
      if (group_en[g] && (group_addr[g] == poll_addr))
      begin
        match.hit      = 1'b1;
        match.is_group = 1'b1;
        match.index    = 4'(g);
      end
    end
    for (int l = addr_map_pkg::N_LINKS - 1; l >= 0; l--)
    begin
      if (link_en[l] && (link_addr[l] == poll_addr))
      begin
        match.hit      = 1'b1;
        match.is_group = 1'b0;
        match.index    = 4'(l);
      end
    end
  end

endmodule : phy_addr_match
`default_nettype wire

/* tb/phy_addr_map_props.sv */
// Checker for the output PHY address map register bank.
`timescale 1ns/100ps
`default_nettype none
module phy_addr_map_props (
  input wire logic                     pclk,            // Clock
  input wire logic                     presetn,         // Reset, low
  input wire logic                     ce,              // Clock enable
  input wire logic                     psel,            // Select
  input wire logic                     penable,         // Access phase
  input wire logic                     pwrite,          // Direction
  input wire logic [11:0]              paddr,           // Byte address
  input wire logic [31:0]              pwdata,          // Write data
  input wire logic [3:0]               pstrb,           // Byte lanes
  input wire logic [31:0]              prdata,          // Read data
  input wire logic                     pready,          // Ready
  input wire logic                     pslverr,         // Error
  input wire addr_map_pkg::phy_addr_t  utopia_addr_pin, // Polled address
  input wire addr_map_pkg::phy_match_s phy_match        // Poll result
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Decode of the access in flight
  wire logic [9:0] idx = paddr[11:2];
  wire logic mapped = idx < 10'h00c || idx == 10'h010 || idx == 10'h011;
  wire logic rd = pready && !pwrite;

  property p_one_wait;
    psel && penable && !pready && ce |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("late ready");
  property p_pulse;
    pready && ce |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_unmapped;
    pready |-> pslverr == !mapped;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad decode");
  property p_err_data;
    pready && pslverr |-> prdata == 32'h0000_0000;
  endproperty
  a_err_data: assert property (p_err_data) else $error("error data");
  property p_gaps;
    rd && idx < 10'h00c |-> prdata[15:13] == 3'h0 && prdata[7:5] == 3'h0;
  endproperty
  a_gaps: assert property (p_gaps) else $error("unused bits set");
  property p_upper;
    rd |-> prdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper half set");
  property p_group_en;
    rd && idx == 10'h011 |-> prdata[15:8] == 8'h00;
  endproperty
  a_group_en: assert property (p_group_en) else $error("group en");
  property p_reset;
    $rose(presetn) |-> phy_match == 6'h00 && !pready;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value");
  // Quiet pin and no writes: the answer must not wander
  property p_hold;
    (ce && !(psel && pwrite) && $stable(utopia_addr_pin))[*8]
      |=> $stable(phy_match);
  endproperty
  a_hold: assert property (p_hold) else $error("match moved");

  c_read: cover property (rd && !pslverr);
  c_err: cover property (pready && pslverr);
  c_group: cover property (phy_match.hit && phy_match.is_group);
endmodule : phy_addr_map_props

bind phy_addr_map phy_addr_map_props u_props (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .utopia_addr_pin(utopia_addr_pin), .phy_match(phy_match));
`default_nettype wire

/* tb/atm_poll_model.sv */
// ATM layer master model that polls one PHY address at a time.
`timescale 1ns/100ps
`default_nettype none
module atm_poll_model (
  input  wire logic                    pclk,            // Clock
  input  wire addr_map_pkg::phy_addr_t poll_addr,       // Address wanted
  output var addr_map_pkg::phy_addr_t  utopia_addr_pin  // Driven address
);
  // Address changes just after an edge and then holds
  initial utopia_addr_pin = 5'h00;
  always @(posedge pclk)
    utopia_addr_pin <= poll_addr;
endmodule : atm_poll_model
`default_nettype wire

/* tb/utopia_output_phy_address_map_tb_top.sv */
// Self-checking bench for the output PHY address map block.
`timescale 1ns/100ps
`default_nettype none
module utopia_output_phy_address_map_tb_top;
  typedef struct packed {
    logic [9:0]  idx;
    logic [31:0] wr;
    logic [31:0] exp;
    logic        err;
  } row_s;
  logic                     pclk = 1'b0;
  logic                     presetn = 1'b0;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic [11:0]              paddr = 12'h000;
  logic [31:0]              pwdata = 32'h0;
  logic [3:0]               pstrb = 4'hf;
  logic                     ce = 1'b1;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic [31:0]              rd;
  logic                     err;
  addr_map_pkg::phy_addr_t  poll_addr = 5'h00;
  addr_map_pkg::phy_addr_t  pin;
  addr_map_pkg::phy_match_s phy_match;
  int                       failures = 0;
  int                       total_checks = 0;
  // Write value, expected read back, expected error
  row_s rows [7] = '{
    '{10'h000, 32'hffff_ffff, 32'h0000_1f1f, 1'b0},
    '{10'h007, 32'h0000_1a05, 32'h0000_1a05, 1'b0},
    '{10'h008, 32'hffff_ffff, 32'h0000_1f1f, 1'b0},
    '{10'h00b, 32'hffff_0c13, 32'h0000_0c13, 1'b0},
    '{10'h010, 32'hffff_ffff, 32'h0000_ffff, 1'b0},
    '{10'h011, 32'hffff_ffff, 32'h0000_00ff, 1'b0},
    '{10'h00c, 32'hffff_ffff, 32'h0000_0000, 1'b1}};

  phy_addr_map dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .utopia_addr_pin(pin), .phy_match(phy_match));
  atm_poll_model far (.pclk(pclk), .poll_addr(poll_addr),
    .utopia_addr_pin(pin));

  // Free-running 100 MHz clock
  initial
  begin
    forever #5 pclk = ~pclk;
  end

  task automatic summarize;
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; an idle edge first so psel never toggles twice
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
    begin
      failures++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Pin sync plus config latency both fit in ten edges
  task automatic poll(input logic [4:0] a, input logic [5:0] exp);
    poll_addr <= a;
    repeat (10) @(posedge pclk);
    chk({26'h0, phy_match}, {26'h0, exp});
  endtask : poll

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 18; i++)
    begin
      apb(1'b0, 10'(i), 32'h0);
      chk(rd, 32'h0);
    end
    chk({26'h0, phy_match}, 32'h0);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].idx, rows[i].wr);
      apb(1'b0, rows[i].idx, 32'h0);
      chk(rd, rows[i].exp);
      chk({31'h0, err}, {31'h0, rows[i].err});
    end
    // Upper lane only: link 8 changes, link 0 keeps its field
    pstrb <= 4'h2;
    apb(1'b1, 10'h000, 32'h0000_0405);
    pstrb <= 4'hf;
    apb(1'b0, 10'h000, 32'h0);
    chk(rd, 32'h0000_041f);
    // Link 11 and group 5 carry the probe addresses
    apb(1'b1, 10'h010, 32'h0);
    apb(1'b1, 10'h011, 32'h0);
    apb(1'b1, 10'h003, 32'h0000_0a03);
    apb(1'b1, 10'h009, 32'h0000_1516);
    poll(5'h0a, 6'h00);
    apb(1'b1, 10'h010, 32'h0000_0800);
    poll(5'h0a, 6'h2b);
    poll(5'h03, 6'h00);
    poll(5'h15, 6'h00);
    apb(1'b1, 10'h011, 32'h0000_0020);
    poll(5'h15, 6'h35);
    poll(5'h16, 6'h00);
    // Clock enable low freezes the poll result
    ce <= 1'b0;
    poll(5'h15, 6'h00);
    ce <= 1'b1;
    poll(5'h15, 6'h35);
    // Second reset in mid-run
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 10'h010, 32'h0);
    chk(rd, 32'h0);
    chk({26'h0, phy_match}, 32'h0);
    summarize();
  end
endmodule : utopia_output_phy_address_map_tb_top
`default_nettype wire
